/* src/oft_pkg.sv */
// What this block does
// - Sixteen-bit bus, two-clock accesses, no waits
// - Pipeline holds two words, prefetches up to three
// - Branch takes at least three bus cycles
// - Branch prefetches only words it needs
// - Late displacement adds one clock delay
// - Next prefetch waits until next instruction is taken
// - Short extension word waits one cycle first
// - Long operand: two bus cycles, plus two clocks
// - Pending write runs during next instruction head
// - Head busy: prefetches move mid or after tail
// - Saved clocks equal min of tail, head
// - Head is free cycles at instruction start
// - Tail is cycles spent on own bus access
// - Entry gives clocks plus read/fetch counts
// - Register operand costs zero clocks, no access
// - Indirect/postinc 1/1/3, predec 2/2/4
// - Absolute word 1/3/5, long 1/5/7
// - Immediate 1/1/3, long immediate 1/3/5
// - Short indexed or index-only 4/2/8
// - Absolute-base indirect 1/5/9, three fetches
// - Unhidden tail adds when next head zero
// - Change of flow: two idle clocks, one prefetch
package oft_pkg;
   localparam int unsigned BUS_W        = 16;
   localparam logic [3:0]  BUS_CLKS     = 4'h2;
   localparam logic [3:0]  LONG_ADD     = 4'h2;
   localparam logic [3:0]  COF_IDLE     = 4'h2;
   localparam logic [3:0]  BR_MIN_CYC   = 4'h3;
   localparam logic [3:0]  EXT_WAIT     = 4'h1;
   localparam logic [3:0]  DISP_LATE    = 4'h1;
   localparam int unsigned PIPE_MIN     = 2;
   localparam int unsigned PIPE_MAX     = 3;
   localparam int unsigned NUM_MODES    = 16;

   typedef enum logic [3:0] {
      OFT_M_DREG, OFT_M_AREG, OFT_M_IND, OFT_M_POSTINC, OFT_M_PREDEC, OFT_M_DISP16,
      OFT_M_ABSW, OFT_M_ABSL, OFT_M_IMMB, OFT_M_IMMW, OFT_M_IMML, OFT_M_IDX8,
      OFT_M_SUPP, OFT_M_MI_D16, OFT_M_MI_D32, OFT_M_MI_IDX
   } oft_mode_t;

   // Packed table entry: head, tail, cycles, reads, prefetches, long-sensitive
   typedef struct packed {
      logic [3:0] head;
      logic [3:0] tail;
      logic [3:0] cyc;
      logic [1:0] rd;
      logic [1:0] pf;
      logic       xrd;
   } oft_ent_t;
endpackage

/* src/oft_mode_rom.sv */
`timescale 1ns/1ps
`default_nettype none
module oft_mode_rom (
   input  wire logic               mclk,
   input  wire logic               rst_b,
   input  wire logic [3:0]         mode,
   output var oft_pkg::oft_ent_t   ent_q
);
   oft_pkg::oft_ent_t ent_d;

   // Word-size fetch timing per operand location mode
   always_comb begin
      ent_d = '0;
      case (oft_pkg::oft_mode_t'(mode))
         oft_pkg::OFT_M_DREG,
         oft_pkg::OFT_M_AREG:    ent_d = '0;
         oft_pkg::OFT_M_IND,
         oft_pkg::OFT_M_POSTINC: ent_d = '{4'h1, 4'h1, 4'h3, 2'h1, 2'h0, 1'b1};
         oft_pkg::OFT_M_PREDEC:  ent_d = '{4'h2, 4'h2, 4'h4, 2'h1, 2'h0, 1'b1};
         oft_pkg::OFT_M_DISP16,
         oft_pkg::OFT_M_ABSW:    ent_d = '{4'h1, 4'h3, 4'h5, 2'h1, 2'h1, 1'b1};
         oft_pkg::OFT_M_ABSL:    ent_d = '{4'h1, 4'h5, 4'h7, 2'h1, 2'h2, 1'b1};
         oft_pkg::OFT_M_IMMB,
         oft_pkg::OFT_M_IMMW:    ent_d = '{4'h1, 4'h1, 4'h3, 2'h0, 2'h1, 1'b0};
         oft_pkg::OFT_M_IMML:    ent_d = '{4'h1, 4'h3, 4'h5, 2'h0, 2'h2, 1'b0};
         oft_pkg::OFT_M_IDX8,
         oft_pkg::OFT_M_MI_IDX:  ent_d = '{4'h4, 4'h2, 4'h8, 2'h1, 2'h1, 1'b1};
         oft_pkg::OFT_M_SUPP:    ent_d = '{4'h2, 4'h2, 4'h6, 2'h1, 2'h1, 1'b1};
         oft_pkg::OFT_M_MI_D16:  ent_d = '{4'h1, 4'h3, 4'h7, 2'h1, 2'h2, 1'b1};
         oft_pkg::OFT_M_MI_D32:  ent_d = '{4'h1, 4'h5, 4'h9, 2'h1, 2'h3, 1'b1};
         default:                ent_d = '0;
      endcase
   end

   // Registered read so the table looks like a small ROM
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ent_q <= '0;
      end else begin
         ent_q <= ent_d;
      end
   end
endmodule
`default_nettype wire

/* src/oft_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
module oft_sync3 (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic din,
   output logic      dout_q
);
   logic s1_q, s2_q, s3_q;
   logic s1_d, s2_d, s3_d, dout_d;

   // Level follows once second and third stages agree
   always_comb begin
      s1_d   = din;
      s2_d   = s1_q;
      s3_d   = s2_q;
      dout_d = (s2_q == s3_q) ? s3_q : dout_q;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         dout_q <= 1'b0;
      end else begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         dout_q <= dout_d;
      end
   end
endmodule
`default_nettype wire

/* src/oft_seq.sv */
`timescale 1ns/1ps
`default_nettype none
// Operand location fetch sequencer with prefetch and trailing-write scheduling.
// One bus cycle at a time on a 16-bit synchronous port; every access takes
// exactly two clocks and the memory never inserts waits.
module oft_seq (
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   // Instruction request (same clock domain except the synchronized disp_late_pin)
   input  wire logic                 ins_valid,
   input  wire logic [3:0]           ins_mode,
   input  wire logic                 ins_long,
   input  wire logic                 ins_branch,
   input  wire logic                 ins_taken,
   input  wire logic                 ins_needs_ext,
   input  wire logic [3:0]           ins_op_head,
   input  wire logic [3:0]           ins_op_cyc,
   input  wire logic                 ins_write,
   input  wire logic                 ins_write_long,
   input  wire logic                 disp_late_pin,
   output logic                      ins_ready_q,
   output logic                      ins_done_q,
   // Memory bus
   output logic                      bus_req_q,
   output logic                      bus_fetch_q,
   output logic                      bus_write_q,
   output logic                      bus_idle_q,
   // Timing report
   output logic [3:0]                rep_head_q,
   output logic [3:0]                rep_tail_q,
   output logic [7:0]                rep_cyc_q,
   output logic [2:0]                rep_rd_q,
   output logic [2:0]                rep_pf_q,
   output logic [1:0]                rep_wr_q,
   output logic [3:0]                rep_saved_q,
   output logic [1:0]                pipe_words_q
);
   typedef enum logic [2:0] {
      OFT_S_IDLE, OFT_S_LOOK, OFT_S_HEAD, OFT_S_BODY, OFT_S_TAIL, OFT_S_REFILL
   } oft_state_t;

   oft_pkg::oft_ent_t ent_q;
   logic              disp_late_q;
   oft_state_t        st_q, st_d;
   logic [3:0]        cnt_q, cnt_d;
   logic [7:0]        tot_q, tot_d;
   logic [1:0]        bus_q, bus_d;        // Clocks left in current bus cycle
   logic              bus_wr_q, bus_wr_d;
   logic [1:0]        rd_left_q, rd_left_d;
   logic [1:0]        pf_left_q, pf_left_d;
   logic [1:0]        wr_pend_q, wr_pend_d;
   logic [1:0]        nwr_q, nwr_d;
   logic [1:0]        pipe_q, pipe_d;
   logic [3:0]        prev_tail_q, prev_tail_d;
   logic              ext_age_q, ext_age_d;
   logic              br_q, br_d, tk_q, tk_d, lng_q, lng_d, wr_q, wr_d, wl_q, wl_d;
   logic [3:0]        oph_q, oph_d, opc_q, opc_d;
   logic [3:0]        head_d, tail_d, saved_d;
   logic [7:0]        cyc_d;
   logic [2:0]        rrd_d, rpf_d;
   logic [1:0]        rwr_d;
   logic              done_d, ready_d, req_d, fetch_d, idle_d;
   logic              start_bus, want_rd, want_wr, want_pf;
   logic [3:0]        eff_tail, eff_cyc;
   logic [7:0]        br_min;

   oft_mode_rom u_rom (
      .mclk  (mclk),
      .rst_b (rst_b),
      .mode  (ins_mode),
      .ent_q (ent_q)
   );

   oft_sync3 u_sync (
      .mclk   (mclk),
      .rst_b  (rst_b),
      .din    (disp_late_pin),
      .dout_q (disp_late_q)
   );

   // Long operands of sized-read (xrd) modes add one bus cycle and two clocks to tail and total
   always_comb begin
      eff_tail = ent_q.tail;
      eff_cyc  = ent_q.cyc;
      if (lng_q && ent_q.xrd) begin
         eff_tail = ent_q.tail + oft_pkg::LONG_ADD;
         eff_cyc  = ent_q.cyc + oft_pkg::LONG_ADD;
      end
   end

   // Bus arbitration: operand reads beat trailing writes beat prefetches
   always_comb begin
      want_rd   = (st_q == OFT_S_BODY) && (rd_left_q != 2'h0);
      // Queued write waits for the next instruction's head, never the refill
      want_wr   = (wr_pend_q != 2'h0) && (st_q != OFT_S_IDLE) && (st_q != OFT_S_REFILL);
      // Only the refill's extra word grows the pipe, never past three words
      want_pf   = (pf_left_q != 2'h0) && ((st_q != OFT_S_REFILL) || (pipe_q < 2'(oft_pkg::PIPE_MAX)));
      // Late displacement clock comes on top of the branch minimum
      br_min    = 8'(oft_pkg::BR_MIN_CYC * oft_pkg::BUS_CLKS) + {7'h00, ext_age_q};
      start_bus = (bus_q == 2'h0) && (want_rd || want_wr || want_pf);
   end

   // Sequencer next state
   always_comb begin
      st_d      = st_q;
      cnt_d     = cnt_q;
      tot_d     = tot_q;
      bus_d     = (bus_q != 2'h0) ? bus_q - 2'h1 : 2'h0;
      bus_wr_d  = bus_wr_q;
      rd_left_d = rd_left_q;
      pf_left_d = pf_left_q;
      wr_pend_d = wr_pend_q;
      nwr_d     = nwr_q;
      pipe_d    = pipe_q;
      prev_tail_d = prev_tail_q;
      ext_age_d = ext_age_q;
      br_d = br_q; tk_d = tk_q; lng_d = lng_q; wr_d = wr_q; wl_d = wl_q;
      oph_d = oph_q; opc_d = opc_q;
      head_d = rep_head_q; tail_d = rep_tail_q; cyc_d = rep_cyc_q;
      rrd_d = rep_rd_q; rpf_d = rep_pf_q; rwr_d = rep_wr_q; saved_d = rep_saved_q;
      done_d  = 1'b0;
      ready_d = 1'b0;
      req_d   = 1'b0;
      fetch_d = 1'b0;
      idle_d  = 1'b0;
      if (st_q != OFT_S_IDLE) begin
         tot_d = tot_q + 8'h01;
      end
      // Launch one two-clock bus cycle when the bus is free
      if (start_bus) begin
         bus_d = 2'(oft_pkg::BUS_CLKS) - 2'h1;
         req_d = 1'b1;
         if (want_rd) begin
            rd_left_d = rd_left_q - 2'h1;
            bus_wr_d  = 1'b0;
         end else if (want_wr) begin
            wr_pend_d = wr_pend_q - 2'h1;
            nwr_d     = nwr_q + 2'h1;
            bus_wr_d  = 1'b1;
         end else begin
            pf_left_d = pf_left_q - 2'h1;
            // Extension prefetches only replace words already consumed
            if (st_q == OFT_S_REFILL) begin
               pipe_d = pipe_q + 2'h1;
            end
            fetch_d   = 1'b1;
            bus_wr_d  = 1'b0;
         end
      end
      case (st_q)
         OFT_S_IDLE: begin
            ready_d = 1'b1;
            // No bus cycle starts here; queued writes wait for the next instruction
            if (ins_valid && ins_ready_q) begin
               br_d = ins_branch; tk_d = ins_taken; lng_d = ins_long;
               wr_d = ins_write; wl_d = ins_write_long;
               oph_d = ins_op_head; opc_d = ins_op_cyc;
               ext_age_d = !ins_needs_ext;
               tot_d = 8'h00;
               nwr_d = 2'h0;
               ready_d = 1'b0;
               st_d  = OFT_S_LOOK;
            end
         end
         OFT_S_LOOK: begin
            // Table entry arrives this cycle
            rd_left_d = ent_q.xrd ? (lng_q ? 2'h2 : 2'h1) : ent_q.rd;
            pf_left_d = br_q ? 2'(oft_pkg::BR_MIN_CYC) - 2'h1 : ent_q.pf;
            head_d = ent_q.head;
            tail_d = eff_tail;
            // Clocks saved: lesser of previous tail and this head
            // Register operands have no location time; the operation head counts
            saved_d = (ent_q.cyc == 4'h0) ? oph_q : ent_q.head;
            saved_d = (prev_tail_q < saved_d) ? prev_tail_q : saved_d;
            rrd_d = 3'(rd_left_d);
            rpf_d = 3'(pf_left_d);
            cnt_d = ent_q.head;
            st_d  = (ent_q.cyc == 4'h0) ? OFT_S_BODY : OFT_S_HEAD;
            if (ent_q.cyc == 4'h0) begin
               cnt_d = 4'h0;
            end
         end
         OFT_S_HEAD: begin
            // Head clocks serve any pending write first; prefetch otherwise
            ext_age_d = 1'b1;
            if (cnt_q <= 4'h1) begin
               if (ext_age_q) begin
                  st_d  = OFT_S_BODY;
                  cnt_d = eff_cyc - ent_q.head - eff_tail;
               end
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         OFT_S_BODY: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (rd_left_q == 2'h0 && !(start_bus && want_rd)) begin
               // Tail covers own access; next head zero leaves it exposed
               cnt_d = eff_tail + oph_q;
               st_d  = OFT_S_TAIL;
               ext_age_d = 1'b0;
            end
         end
         OFT_S_TAIL: begin
            // Prefetches blocked by a write get pushed past the tail
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (pf_left_q == 2'h0 && wr_pend_q == 2'h0 && bus_q == 2'h0 && !start_bus) begin
               if (br_q && disp_late_q && !ext_age_q) begin
                  // Late displacement: hold one clock before using it
                  ext_age_d = 1'b1;
               end else begin
                  if (wr_q) begin
                     wr_pend_d = wr_pend_d + (wl_q ? 2'h2 : 2'h1);
                  end
                  if (br_q && tk_q) begin
                     cnt_d  = oft_pkg::COF_IDLE;
                     pipe_d = 2'(oft_pkg::PIPE_MIN);
                     pf_left_d = 2'h1;
                     st_d   = OFT_S_REFILL;
                  end else begin
                     st_d = OFT_S_IDLE;
                     done_d = 1'b1;
                  end
                  // Branch never shorter than three bus cycles; others report the table
                  cyc_d = br_q ? ((tot_q < br_min) ? br_min : tot_q) : {4'h0, eff_cyc};
                  rwr_d = nwr_q + ((wr_q) ? (wl_q ? 2'h2 : 2'h1) : 2'h0);
                  // Own trailing write belongs to the tail
                  prev_tail_d = eff_tail + (wr_q ? (wl_q ? oft_pkg::BUS_CLKS << 1 : oft_pkg::BUS_CLKS) : 4'h0);
                  pipe_d = (pipe_d > 2'(oft_pkg::PIPE_MIN)) ? pipe_d - 2'h1 : pipe_d;
               end
            end
         end
         OFT_S_REFILL: begin
            idle_d = 1'b1;
            if (cnt_q <= 4'h1) begin
               st_d   = OFT_S_IDLE;
               done_d = 1'b1;
               prev_tail_d = 4'h0;
               // An extra word the full pipe could not take is dropped
               pf_left_d = 2'h0;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: st_d = OFT_S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= OFT_S_IDLE;
         cnt_q <= 4'h0; tot_q <= 8'h00; bus_q <= 2'h0; bus_wr_q <= 1'b0;
         rd_left_q <= 2'h0; pf_left_q <= 2'h0; wr_pend_q <= 2'h0; nwr_q <= 2'h0;
         pipe_q <= 2'h2; prev_tail_q <= 4'h0; ext_age_q <= 1'b0;
         br_q <= 1'b0; tk_q <= 1'b0; lng_q <= 1'b0; wr_q <= 1'b0; wl_q <= 1'b0;
         oph_q <= 4'h0; opc_q <= 4'h0;
         ins_ready_q <= 1'b0; ins_done_q <= 1'b0;
         bus_req_q <= 1'b0; bus_fetch_q <= 1'b0; bus_write_q <= 1'b0; bus_idle_q <= 1'b0;
         rep_head_q <= 4'h0; rep_tail_q <= 4'h0; rep_cyc_q <= 8'h00;
         rep_rd_q <= 3'h0; rep_pf_q <= 3'h0; rep_wr_q <= 2'h0; rep_saved_q <= 4'h0;
         pipe_words_q <= 2'h2;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d; tot_q <= tot_d; bus_q <= bus_d; bus_wr_q <= bus_wr_d;
         rd_left_q <= rd_left_d; pf_left_q <= pf_left_d; wr_pend_q <= wr_pend_d; nwr_q <= nwr_d;
         pipe_q <= pipe_d; prev_tail_q <= prev_tail_d; ext_age_q <= ext_age_d;
         br_q <= br_d; tk_q <= tk_d; lng_q <= lng_d; wr_q <= wr_d; wl_q <= wl_d;
         oph_q <= oph_d; opc_q <= opc_d;
         ins_ready_q <= ready_d; ins_done_q <= done_d;
         bus_req_q <= req_d; bus_fetch_q <= fetch_d; bus_write_q <= req_d & bus_wr_d;
         bus_idle_q <= idle_d;
         rep_head_q <= head_d; rep_tail_q <= tail_d; rep_cyc_q <= cyc_d;
         rep_rd_q <= rrd_d; rep_pf_q <= rpf_d; rep_wr_q <= rwr_d; rep_saved_q <= saved_d;
         pipe_words_q <= pipe_d;
      end
   end
endmodule
`default_nettype wire

/* tb/oft_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Zero-wait 16-bit synchronous memory; it only tallies the bus cycles it serves
module oft_mem_model (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic clr,
   input  wire logic bus_req_q,
   input  wire logic bus_fetch_q,
   input  wire logic bus_write_q,
   output var int    n_rd,
   output var int    n_pf,
   output var int    n_wr
);
   // Every request completes in two clocks, no waits inserted
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         n_rd <= 0;
         n_pf <= 0;
         n_wr <= 0;
      end else if (clr) begin
         n_rd <= 0;
         n_pf <= 0;
         n_wr <= 0;
      end else if (bus_req_q) begin
         if (bus_fetch_q) n_pf <= n_pf + 1;
         else if (bus_write_q) n_wr <= n_wr + 1;
         else n_rd <= n_rd + 1;
      end
   end
endmodule
`default_nettype wire

/* tb/oft_seq_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module oft_seq_chk (
   input  wire logic       mclk,
   input  wire logic       rst_b,
   input  wire logic       ins_valid,
   input  wire logic       ins_ready_q,
   input  wire logic       ins_done_q,
   input  wire logic       bus_req_q,
   input  wire logic       bus_fetch_q,
   input  wire logic       bus_write_q,
   input  wire logic       bus_idle_q,
   input  wire logic [1:0] pipe_words_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Bus cycles last two clocks, so requests never sit back to back
   bus_two_clk_a: assert property (bus_req_q |=> !bus_req_q)
      else $error("bus request on consecutive clocks");
   pipe_depth_a: assert property (pipe_words_q >= 2'h2)
      else $error("pipeline below two words");
   fetch_qual_a: assert property (bus_fetch_q |-> bus_req_q)
      else $error("fetch flag without bus request");
   write_qual_a: assert property (bus_write_q |-> bus_req_q && !bus_fetch_q)
      else $error("write flag malformed");
   done_pulse_a: assert property (ins_done_q |=> !ins_done_q)
      else $error("done longer than one clock");
   take_busy_a: assert property (ins_valid && ins_ready_q |=> !ins_ready_q)
      else $error("ready stayed high after take");
   idle_two_a: assert property ($rose(bus_idle_q) |=> bus_idle_q ##1 !bus_idle_q)
      else $error("change of flow idle not two clocks");
   idle_use_a: assert property (bus_idle_q && bus_req_q |-> bus_fetch_q)
      else $error("idle period used for non-prefetch");
   c_write: cover property (bus_write_q);
   c_idle: cover property ($rose(bus_idle_q));
   c_done: cover property (ins_done_q);
endmodule
`default_nettype wire

/* tb/oft_seq_test.sv */
`timescale 1ns/1ps
`default_nettype none
module oft_seq_test;
   logic       mclk = 1'b0, rst_b = 1'b0, clr = 1'b0;
   logic       ins_valid = 1'b0, ins_long = 1'b0, ins_branch = 1'b0, ins_taken = 1'b0;
   logic       ins_needs_ext = 1'b0, ins_write = 1'b0, ins_write_long = 1'b0, disp_late_pin = 1'b0;
   logic [3:0] ins_mode = 4'h0, ins_op_head = 4'h0, ins_op_cyc = 4'h0;
   logic       ins_ready_q, ins_done_q, bus_req_q, bus_fetch_q, bus_write_q, bus_idle_q;
   logic [3:0] rep_head_q, rep_tail_q, rep_saved_q;
   logic [7:0] rep_cyc_q;
   logic [2:0] rep_rd_q, rep_pf_q;
   logic [1:0] rep_wr_q, pipe_words_q;
   int         n_rd, n_pf, n_wr, fails = 0, num_checks = 0, idle_seen;
   always #12.5 mclk = ~mclk;
   oft_seq oft_seq_inst (.mclk(mclk), .rst_b(rst_b), .ins_valid(ins_valid), .ins_mode(ins_mode),
      .ins_long(ins_long), .ins_branch(ins_branch), .ins_taken(ins_taken), .ins_needs_ext(ins_needs_ext),
      .ins_op_head(ins_op_head), .ins_op_cyc(ins_op_cyc), .ins_write(ins_write),
      .ins_write_long(ins_write_long), .disp_late_pin(disp_late_pin), .ins_ready_q(ins_ready_q),
      .ins_done_q(ins_done_q), .bus_req_q(bus_req_q), .bus_fetch_q(bus_fetch_q), .bus_write_q(bus_write_q),
      .bus_idle_q(bus_idle_q), .rep_head_q(rep_head_q), .rep_tail_q(rep_tail_q), .rep_cyc_q(rep_cyc_q),
      .rep_rd_q(rep_rd_q), .rep_pf_q(rep_pf_q), .rep_wr_q(rep_wr_q), .rep_saved_q(rep_saved_q),
      .pipe_words_q(pipe_words_q));
   oft_mem_model oft_mem_model_inst (.mclk(mclk), .rst_b(rst_b), .clr(clr), .bus_req_q(bus_req_q),
      .bus_fetch_q(bus_fetch_q), .bus_write_q(bus_write_q), .n_rd(n_rd), .n_pf(n_pf), .n_wr(n_wr));
   // Counts idle clocks of the current instruction
   always @(posedge mclk) if (clr) idle_seen = 0; else if (bus_idle_q === 1'b1) idle_seen++;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // One instruction: wait ready, offer one clock, wait for done, let reports settle
   task automatic run(input logic [3:0] m, input logic lg, input logic br, input logic wl, input logic [3:0] oh);
      int n;
      n = 0;
      while (ins_ready_q !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
      @(posedge mclk);
      {ins_mode, ins_long, ins_branch, ins_taken, ins_write, ins_write_long} <= {m, lg, br, br, wl, wl};
      ins_op_head <= oh;
      ins_valid <= 1'b1;
      clr <= 1'b1;
      @(posedge mclk);
      ins_valid <= 1'b0;
      clr <= 1'b0;
      n = 0;
      while (ins_done_q !== 1'b1 && n < 200) begin @(negedge mclk); n++; end
      if (n >= 200) chk(8'h00, 8'h01, "no done");
      repeat (2) @(posedge mclk);
      #1;
   endtask
   // Operand location table, word size: {head, tail, cyc, reads, prefetches}
   function automatic logic [19:0] ent(input logic [3:0] m);
      case (m)
         4'h2, 4'h3: ent = 20'h11314;
         4'h4:       ent = 20'h22414;
         4'h5, 4'h6: ent = 20'h13515;
         4'h7:       ent = 20'h15716;
         4'h8, 4'h9: ent = 20'h11301;
         4'hA:       ent = 20'h13502;
         4'hB, 4'hF: ent = 20'h42815;
         4'hC:       ent = 20'h22615;
         4'hD:       ent = 20'h13716;
         4'hE:       ent = 20'h15917;
         default:    ent = 20'h00000;
      endcase
   endfunction
   // Sweep every mode, word then long where a read is sized
   task automatic t_modes();
      logic [19:0] e;
      logic [7:0]  x;
      for (int m = 0; m < 16; m++) for (int l = 0; l < 2; l++) begin
         e = ent(4'(m));
         if (l == 1 && e[2] == 1'b0) continue;
         run(4'(m), 1'(l), 1'b0, 1'b0, 4'h0);
         x = (l == 1) ? 8'h2 : 8'h0;
         chk({4'h0, rep_head_q}, {4'h0, e[19:16]}, "head");
         chk({4'h0, rep_tail_q}, {4'h0, e[15:12]} + x, "tail");
         chk(rep_cyc_q, {4'h0, e[11:8]} + x, "cycles");
         chk(8'(n_rd), {6'h0, e[5:4]} << l, "reads on bus");
         chk({5'h0, rep_rd_q}, {6'h0, e[5:4]} << l, "reads");
         chk({5'h0, rep_pf_q}, {6'h0, e[1:0]}, "prefetches");
      end
   endtask
   // Taken branch: three bus cycles minimum and the two refill idle clocks
   task automatic t_branch();
      logic [7:0] c0;
      run(4'h0, 1'b0, 1'b1, 1'b0, 4'h0);
      c0 = rep_cyc_q;
      chk(8'(rep_cyc_q >= 8'h6), 8'h1, "branch length");
      chk(8'(idle_seen), 8'h2, "idle clocks");
      chk(8'(n_pf <= 3), 8'h1, "branch overfetch");
      disp_late_pin <= 1'b1;
      repeat (5) @(posedge mclk);
      run(4'h0, 1'b0, 1'b1, 1'b0, 4'h0);
      chk(rep_cyc_q, c0 + 8'h1, "late displacement");
      disp_late_pin <= 1'b0;
   endtask
   // Long trailing write then a four-clock head: the write hides in that head
   task automatic t_trail();
      run(4'h0, 1'b0, 1'b0, 1'b1, 4'h0);
      chk({6'h0, rep_wr_q}, 8'h2, "long write count");
      run(4'h0, 1'b0, 1'b0, 1'b0, 4'h4);
      chk(8'(n_wr), 8'h2, "trailing long write");
      chk({4'h0, rep_saved_q}, 8'h4, "saved clocks");
   endtask
   // Register operand: no reads or writes on the bus
   task automatic t_reg();
      run(4'h1, 1'b0, 1'b0, 1'b0, 4'h0);
      chk(8'(n_rd + n_wr), 8'h0, "register access");
      chk({6'h0, pipe_words_q}, 8'h2, "pipe words");
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (2) @(posedge mclk);
      t_reg();
      t_modes();
      t_branch();
      t_trail();
      close_out();
   end
   // Watchdog well beyond the roughly 500 clocks the run needs
   initial begin
      #2000000;
      fails++;
      close_out();
   end
endmodule
bind oft_seq oft_seq_chk oft_seq_chk_inst (.mclk(mclk), .rst_b(rst_b), .ins_valid(ins_valid),
   .ins_ready_q(ins_ready_q), .ins_done_q(ins_done_q), .bus_req_q(bus_req_q), .bus_fetch_q(bus_fetch_q),
   .bus_write_q(bus_write_q), .bus_idle_q(bus_idle_q), .pipe_words_q(pipe_words_q));
`default_nettype wire
